/* File: core/cpw_pkg.sv */
package cpw_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_UNIT1_CTRL  = 8'h00;
  localparam logic [7:0] OFF_UNIT2_CTRL  = 8'h04;
  localparam logic [7:0] OFF_DUTY1_LOW   = 8'h08;
  localparam logic [7:0] OFF_DUTY1_SHAD  = 8'h0c;
  localparam logic [7:0] OFF_DUTY2_LOW   = 8'h10;
  localparam logic [7:0] OFF_DUTY2_SHAD  = 8'h14;
  localparam logic [7:0] OFF_PERIOD      = 8'h18;
  localparam logic [7:0] OFF_CNT_CFG     = 8'h1c;
  localparam logic [7:0] OFF_BASE_CNT    = 8'h20;
  localparam logic [7:0] OFF_PIN_CFG     = 8'h24;
  localparam logic [7:0] OFF_STATUS      = 8'h28;

  // field positions
  localparam int FRAC_HI      = 5;
  localparam int FRAC_LO      = 4;
  localparam int MODE_HI      = 3;
  localparam int CFG_ON_BIT   = 2;
  localparam int PIN_DIR1_BIT = 0;
  localparam int PIN_DIR2_BIT = 1;
  localparam int PIN_SEL_BIT  = 2;

  // reset values
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'hff;
  localparam logic [7:0] RST_CNT_CFG = 8'h00;
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_DUTY    = 8'h00;
  localparam logic [2:0] RST_PIN_CFG = 3'h3;

  // mode code selecting pulse-width operation (upper two bits set)
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  typedef enum logic [1:0] {
    CPW_PRE_1  = 2'b00,
    CPW_PRE_4  = 2'b01,
    CPW_PRE_16 = 2'b10
  } cpw_pre_t;

  typedef struct packed {
    logic [7:0] duty_low;
    logic [1:0] frac;
  } cpw_duty_t;

endpackage

/* File: core/cpw_top.sv */
`timescale 1ns/1ns
module cpw_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // power state
  input  wire logic        sleep_i,
  // port latch values when the unit does not own a pin
  input  wire logic        port1_data_i,
  input  wire logic        port2a_data_i,
  input  wire logic        port2b_data_i,
  // pins
  output logic             pwm1_pin_o,
  output logic             pwm1_pin_oe_o,
  output logic             pwm2a_pin_o,
  output logic             pwm2a_pin_oe_o,
  output logic             pwm2b_pin_o,
  output logic             pwm2b_pin_oe_o
);

  logic       rst_meta_r;
  logic       rstn_r;
  logic [7:0] ctrl_r [2];
  logic [7:0] duty_low_r [2];
  logic [7:0] shadow_r [2];
  logic [1:0] latch_r [2];
  logic       out_r [2];
  logic [7:0] period_r;
  logic [7:0] cfg_r;
  logic [7:0] count_r;
  logic [3:0] pre_r;
  logic [2:0] pin_cfg_r;
  logic       tick;
  logic       match;
  logic       inc;
  logic [1:0] low_bits;
  logic [9:0] time_base;
  logic       pwm_on [2];
  logic       wr;
  logic       rd;
  logic       addr_ok;

  // reset release through two flops
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rstn_r     <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rstn_r     <= rst_meta_r;
    end
  end

  localparam int MODE_HI = cpw_pkg::MODE_HI;
  localparam int FRAC_HI = cpw_pkg::FRAC_HI;
  localparam int FRAC_LO = cpw_pkg::FRAC_LO;

  function automatic logic is_pwm(input logic [7:0] c);
    is_pwm = (c[MODE_HI -: 2] == cpw_pkg::MODE_PWM_TOP);
  endfunction

  assign pwm_on[0] = is_pwm(ctrl_r[0]);
  assign pwm_on[1] = is_pwm(ctrl_r[1]);

  // apb: zero wait states, every access answered in its access cycle
  assign wr        = psel_i & penable_i & pwrite_i;
  assign rd        = psel_i & penable_i & ~pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;

  // one write strobe per shared register
  logic       wr_period;
  logic       wr_cfg;
  logic       wr_pin_cfg;
  logic       wr_count;
  assign wr_period  = wr && (paddr_i == cpw_pkg::OFF_PERIOD);
  assign wr_cfg     = wr && (paddr_i == cpw_pkg::OFF_CNT_CFG);
  assign wr_pin_cfg = wr && (paddr_i == cpw_pkg::OFF_PIN_CFG);
  assign wr_count   = wr && (paddr_i == cpw_pkg::OFF_BASE_CNT);

  // read data is captured in the setup cycle
  logic       rd_setup;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;

  always_comb begin
    case (paddr_i)
      cpw_pkg::OFF_UNIT1_CTRL, cpw_pkg::OFF_UNIT2_CTRL,
      cpw_pkg::OFF_DUTY1_LOW,  cpw_pkg::OFF_DUTY1_SHAD,
      cpw_pkg::OFF_DUTY2_LOW,  cpw_pkg::OFF_DUTY2_SHAD,
      cpw_pkg::OFF_PERIOD,     cpw_pkg::OFF_CNT_CFG,
      cpw_pkg::OFF_BASE_CNT,   cpw_pkg::OFF_PIN_CFG,
      cpw_pkg::OFF_STATUS: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // prescaler: four system ticks form one instruction tick
  // ratio 1 uses clock phase, others prescaler bits
  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      pre_r <= 4'h0;
    end else if (!sleep_i && cfg_r[cpw_pkg::CFG_ON_BIT]) begin
      pre_r <= pre_r + 4'h1;
    end
  end

  always_comb begin
    case (cpw_pre_sel(cfg_r[1:0]))
      cpw_pkg::CPW_PRE_4: begin
        tick     = (pre_r == 4'hf);
        low_bits = pre_r[3:2];
      end
      cpw_pkg::CPW_PRE_16: begin
        tick     = 1'b0;
        low_bits = 2'h0;
      end
      default: begin
        tick     = (pre_r[1:0] == 2'h3);
        low_bits = pre_r[1:0];
      end
    endcase
  end

  function automatic cpw_pkg::cpw_pre_t cpw_pre_sel(input logic [1:0] v);
    cpw_pre_sel = (v == 2'h0) ? cpw_pkg::CPW_PRE_1 :
                  (v == 2'h1) ? cpw_pkg::CPW_PRE_4 : cpw_pkg::CPW_PRE_16;
  endfunction

  // prescale 16: a wider counter provides the bits and the tick
  logic [5:0] pre16_r;
  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      pre16_r <= 6'h00;
    end else if (!sleep_i && cfg_r[cpw_pkg::CFG_ON_BIT]) begin
      pre16_r <= pre16_r + 6'h01;
    end
  end

  logic       tick_eff;
  logic [1:0] low_eff;
  assign tick_eff = (cpw_pre_sel(cfg_r[1:0]) == cpw_pkg::CPW_PRE_16) ?
                    (pre16_r == 6'h3f) : tick;
  assign low_eff  = (cpw_pre_sel(cfg_r[1:0]) == cpw_pkg::CPW_PRE_16) ?
                    pre16_r[5:4] : low_bits;

  assign inc       = tick_eff & ~sleep_i & cfg_r[cpw_pkg::CFG_ON_BIT];
  assign match     = (count_r == period_r);
  assign time_base = {count_r, low_eff};

  // pin must drop in the clock where the time base reaches the duty,
  // so the clear is registered on the edge that advances it
  logic       tb_run;
  logic       tb_step;
  logic [9:0] tb_next;
  assign tb_run  = ~sleep_i & cfg_r[cpw_pkg::CFG_ON_BIT];
  assign tb_next = time_base + 10'h001;
  always_comb begin
    case (cpw_pre_sel(cfg_r[1:0]))
      cpw_pkg::CPW_PRE_4: begin
        tb_step = (pre_r[1:0] == 2'h3);
      end
      cpw_pkg::CPW_PRE_16: begin
        tb_step = (pre16_r[3:0] == 4'hf);
      end
      default: begin
        tb_step = 1'b1;
      end
    endcase
  end

  // base counter; postscaler bits of cfg are stored only
  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      count_r <= cpw_pkg::RST_COUNT;
    end else if (wr_count) begin
      count_r <= pwdata_i[7:0];
    end else if (inc) begin
      count_r <= match ? 8'h00 : count_r + 8'h01;
    end
  end

  // per-unit duty buffering and output
  for (genvar u = 0; u < 2; u++) begin : g_unit
    logic [7:0] ctrl_off;
    logic [7:0] low_off;
    assign ctrl_off = u ? cpw_pkg::OFF_UNIT2_CTRL : cpw_pkg::OFF_UNIT1_CTRL;
    assign low_off  = u ? cpw_pkg::OFF_DUTY2_LOW : cpw_pkg::OFF_DUTY1_LOW;

    always_ff @(posedge ref_clk_i or negedge rstn_r) begin
      if (!rstn_r) begin
        ctrl_r[u] <= cpw_pkg::RST_CTRL;
      end else if (wr && paddr_i == ctrl_off) begin
        ctrl_r[u] <= {2'h0, pwdata_i[5:0]};
      end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_r) begin
      if (!rstn_r) begin
        duty_low_r[u] <= cpw_pkg::RST_DUTY;
      end else if (wr && paddr_i == low_off) begin
        duty_low_r[u] <= pwdata_i[7:0];
      end
    end

    // shadow: writable by software only outside pulse-width mode
    logic [7:0] shad_off;
    assign shad_off = u ? cpw_pkg::OFF_DUTY2_SHAD : cpw_pkg::OFF_DUTY1_SHAD;
    always_ff @(posedge ref_clk_i or negedge rstn_r) begin
      if (!rstn_r) begin
        shadow_r[u] <= cpw_pkg::RST_DUTY;
      end else if (pwm_on[u] && inc && match) begin
        shadow_r[u] <= duty_low_r[u];
      end else if (!pwm_on[u] && wr && paddr_i == shad_off) begin
        shadow_r[u] <= pwdata_i[7:0];
      end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_r) begin
      if (!rstn_r) begin
        latch_r[u] <= 2'h0;
      end else if (pwm_on[u] && inc && match) begin
        latch_r[u] <= ctrl_r[u][FRAC_HI:FRAC_LO];
      end
    end

    logic hit;
    assign hit = tb_run & tb_step & (tb_next == {shadow_r[u], latch_r[u]});

    // set on period start unless the new duty is zero, clear on duty match; over-long duty never
    // matches, so pin simply stays high for the whole period
    cpw_pkg::cpw_duty_t nd;
    assign nd = '{duty_low: duty_low_r[u], frac: ctrl_r[u][FRAC_HI:FRAC_LO]};
    always_ff @(posedge ref_clk_i or negedge rstn_r) begin
      if (!rstn_r) begin
        out_r[u] <= 1'b0;
      end else if (!pwm_on[u]) begin
        out_r[u] <= 1'b0;
      end else if (sleep_i) begin
        out_r[u] <= out_r[u];
      end else if (inc && match) begin
        out_r[u] <= (nd != '0);
      end else if (hit) begin
        out_r[u] <= 1'b0;
      end
    end
  end

  // shared registers
  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      period_r <= cpw_pkg::RST_PERIOD;
    end else if (wr_period) begin
      period_r <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      cfg_r <= cpw_pkg::RST_CNT_CFG;
    end else if (wr_cfg) begin
      cfg_r <= {1'b0, pwdata_i[6:0]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      pin_cfg_r <= cpw_pkg::RST_PIN_CFG;
    end else if (wr_pin_cfg) begin
      pin_cfg_r <= pwdata_i[2:0];
    end
  end

  // read mux; unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      cpw_pkg::OFF_UNIT1_CTRL: begin
        read_word = {24'h0, ctrl_r[0]};
      end
      cpw_pkg::OFF_UNIT2_CTRL: begin
        read_word = {24'h0, ctrl_r[1]};
      end
      cpw_pkg::OFF_DUTY1_LOW: begin
        read_word = {24'h0, duty_low_r[0]};
      end
      cpw_pkg::OFF_DUTY1_SHAD: begin
        read_word = {24'h0, shadow_r[0]};
      end
      cpw_pkg::OFF_DUTY2_LOW: begin
        read_word = {24'h0, duty_low_r[1]};
      end
      cpw_pkg::OFF_DUTY2_SHAD: begin
        read_word = {24'h0, shadow_r[1]};
      end
      cpw_pkg::OFF_PERIOD: begin
        read_word = {24'h0, period_r};
      end
      cpw_pkg::OFF_CNT_CFG: begin
        read_word = {24'h0, cfg_r};
      end
      cpw_pkg::OFF_BASE_CNT: begin
        read_word = {24'h0, count_r};
      end
      cpw_pkg::OFF_PIN_CFG: begin
        read_word = {29'h0, pin_cfg_r};
      end
      cpw_pkg::OFF_STATUS: begin
        read_word = {28'h0, latch_r[1][0], latch_r[0][0],
                     out_r[1], out_r[0]};
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  endfunction

  // read data from flops
  always_ff @(posedge ref_clk_i or negedge rstn_r) begin
    if (!rstn_r) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= read_word(paddr_i);
    end
  end

  // pins: unit owns pin while in mode (unit 2 only its selected pin); enable follows direction bit, forced off on the unselected unit 2 pin
  logic p2_sel;
  assign p2_sel = pin_cfg_r[cpw_pkg::PIN_SEL_BIT];

  assign pwm1_pin_o     = pwm_on[0] ? out_r[0] : port1_data_i;
  assign pwm1_pin_oe_o  = ~pin_cfg_r[cpw_pkg::PIN_DIR1_BIT];
  assign pwm2a_pin_o    = (pwm_on[1] && !p2_sel) ? out_r[1] :
                          port2a_data_i;
  assign pwm2a_pin_oe_o = ~pin_cfg_r[cpw_pkg::PIN_DIR2_BIT] & ~p2_sel;
  assign pwm2b_pin_o    = (pwm_on[1] && p2_sel) ? out_r[1] :
                          port2b_data_i;
  assign pwm2b_pin_oe_o = ~pin_cfg_r[cpw_pkg::PIN_DIR2_BIT] & p2_sel;

endmodule

/* File: testbench/cpw_properties.sv */
`timescale 1ns/1ns
module cpw_properties (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // power state, port latch and pins
  input wire logic        sleep_i,
  input wire logic        port1_data_i,
  input wire logic        pwm1_pin_o,
  input wire logic        pwm1_pin_oe_o,
  input wire logic        pwm2a_pin_o
);
  logic [1:0] mode1_r;
  logic       dir1_r;
  logic       wr_en;
  logic       pwm1_on;

  // mirrors of the bits the pin logic depends on
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign pwm1_on = (mode1_r == cpw_pkg::MODE_PWM_TOP);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode1_r <= 2'h0;
      dir1_r  <= 1'b1;
    end else if (wr_en && paddr_i == cpw_pkg::OFF_UNIT1_CTRL) begin
      mode1_r <= pwdata_i[3:2];
    end else if (wr_en && paddr_i == cpw_pkg::OFF_PIN_CFG) begin
      dir1_r <= pwdata_i[0];
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  ready_high_a: assert property (pready_o) else $error("pready low");
  err_phase_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("pslverr outside access");
  err_addr_a: assert property (psel_i && penable_i &&
    paddr_i > cpw_pkg::OFF_STATUS |-> pslverr_o)
    else $error("unmapped access not refused");
  err_read_a: assert property (psel_i && penable_i && !pwrite_i &&
    pslverr_o |-> prdata_o == 32'h0) else $error("unmapped read not 0");
  pin_dir_a: assert property (pwm1_pin_oe_o == !dir1_r)
    else $error("oe does not follow direction bit");
  pin_release_a: assert property (!pwm1_on && !$past(pwm1_on)
    |-> pwm1_pin_o == port1_data_i) else $error("pin not released");
  sleep_freeze_a: assert property (sleep_i [*3]
    |-> $stable(pwm1_pin_o) && $stable(pwm2a_pin_o))
    else $error("pin moved in sleep");
  rise_space_a: assert property ($rose(pwm1_pin_o) && pwm1_on
    |=> !$rose(pwm1_pin_o) [*3]) else $error("period below 4 clocks");
endmodule

bind cpw_top cpw_properties u_props (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .sleep_i(sleep_i), .port1_data_i(port1_data_i),
  .pwm1_pin_o(pwm1_pin_o), .pwm1_pin_oe_o(pwm1_pin_oe_o),
  .pwm2a_pin_o(pwm2a_pin_o)
);

/* File: testbench/cpw_load.sv */
`timescale 1ns/1ns
module cpw_load (
  // clock and pin
  input  wire logic        clk_i,
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  // measured high time and period in clocks
  output logic      [15:0] hi_o,
  output logic      [15:0] per_o
);
  logic        lvl;
  logic        prev = 1'b0;
  logic [15:0] hc = 16'h0;
  logic [15:0] pc = 16'h0;

  // load pulls down, so an undriven pin reads low, not the last value
  assign lvl = oe_i ? pin_i : 1'b0;
  always @(posedge clk_i) begin
    prev <= lvl;
    pc <= pc + 16'h1;
    if (lvl) hc <= hc + 16'h1;
    if (lvl && !prev) begin
      per_o <= pc;
      pc <= 16'h1;
      hc <= 16'h1;
    end
    if (!lvl && prev) hi_o <= hc;
  end
endmodule

/* File: testbench/test_capture_unit_pwm_mode.sv */
`timescale 1ns/1ns
module test_capture_unit_pwm_mode;
  logic ref_clk_i = 1'b0;
  logic resetn_i, psel_i, penable_i, pwrite_i, sleep_i, port1_data_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, err, pwm1_pin_o, pwm1_pin_oe_o;
  logic pwm2a_pin_o, pwm2a_pin_oe_o, pwm2b_pin_o, pwm2b_pin_oe_o;
  logic [15:0] hi, per;
  logic [2:0] any_v, all_v;
  int bad_count = 0;
  int n_compared = 0;

  cpw_top DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
    .port1_data_i(port1_data_i), .port2a_data_i(1'b0),
    .port2b_data_i(1'b0), .pwm1_pin_o(pwm1_pin_o),
    .pwm1_pin_oe_o(pwm1_pin_oe_o), .pwm2a_pin_o(pwm2a_pin_o),
    .pwm2a_pin_oe_o(pwm2a_pin_oe_o), .pwm2b_pin_o(pwm2b_pin_o),
    .pwm2b_pin_oe_o(pwm2b_pin_oe_o));
  cpw_load u_load (.clk_i(ref_clk_i), .pin_i(pwm1_pin_o),
    .oe_i(pwm1_pin_oe_o), .hi_o(hi), .per_o(per));

  always #4 ref_clk_i = ~ref_clk_i;

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // one period at limit 3 and prescale 1
  task automatic watch();
    any_v = 3'h0;
    all_v = 3'h7;
    repeat (16) begin
      @(posedge ref_clk_i);
      any_v = any_v | {pwm2b_pin_o, pwm2a_pin_o, pwm1_pin_o};
      all_v = all_v & {pwm2b_pin_o, pwm2a_pin_o, pwm1_pin_o};
    end
  endtask

  task automatic t_reset();
    apb(1'b0, cpw_pkg::OFF_UNIT1_CTRL, 32'h0);
    chk("ctrl1", 32'h0, rd);
    apb(1'b0, cpw_pkg::OFF_PERIOD, 32'h0);
    chk("period", 32'hff, rd);
    apb(1'b0, cpw_pkg::OFF_PIN_CFG, 32'h0);
    chk("pincfg", 32'h3, rd);
    chk("oe1", 32'h0, pwm1_pin_oe_o);
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped", 32'h1, err);
  endtask

  task automatic t_rates();
    int pre;
    apb(1'b1, cpw_pkg::OFF_PERIOD, 32'h3);
    apb(1'b1, cpw_pkg::OFF_PIN_CFG, 32'h4);
    apb(1'b1, cpw_pkg::OFF_DUTY1_LOW, 32'h2);
    apb(1'b1, cpw_pkg::OFF_UNIT1_CTRL, 32'h1c);
    chk("oe1", 32'h1, pwm1_pin_oe_o);
    for (int i = 0; i < 3; i++) begin
      pre = 1 << (2 * i);
      // postscaler bits set on purpose
      apb(1'b1, cpw_pkg::OFF_CNT_CFG, 32'h7c | i);
      repeat (48 * pre + 8) @(posedge ref_clk_i);
      chk("period", 16 * pre, per);
      chk("high", 9 * pre, hi);
    end
    apb(1'b1, cpw_pkg::OFF_CNT_CFG, 32'h7c);
  endtask

  task automatic t_edges();
    apb(1'b1, cpw_pkg::OFF_DUTY1_LOW, 32'h0);
    apb(1'b1, cpw_pkg::OFF_UNIT1_CTRL, 32'h0c);
    repeat (40) @(posedge ref_clk_i);
    watch();
    chk("zero duty", 32'h0, any_v[0]);
    apb(1'b1, cpw_pkg::OFF_DUTY1_LOW, 32'hff);
    repeat (40) @(posedge ref_clk_i);
    watch();
    chk("over duty", 32'h1, all_v[0]);
    apb(1'b1, cpw_pkg::OFF_DUTY1_SHAD, 32'h55);
    apb(1'b0, cpw_pkg::OFF_DUTY1_SHAD, 32'h0);
    chk("shadow", 32'hff, rd);
  endtask

  task automatic t_sleep_route();
    logic v;
    apb(1'b1, cpw_pkg::OFF_DUTY1_LOW, 32'h2);
    apb(1'b1, cpw_pkg::OFF_UNIT1_CTRL, 32'h1c);
    apb(1'b1, cpw_pkg::OFF_DUTY2_LOW, 32'h1);
    apb(1'b1, cpw_pkg::OFF_UNIT2_CTRL, 32'h0c);
    repeat (40) @(posedge ref_clk_i);
    sleep_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    v = pwm1_pin_o;
    repeat (50) @(posedge ref_clk_i);
    chk("sleep pin", v, pwm1_pin_o);
    sleep_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    chk("wake period", 32'h10, per);
    watch();
    chk("unit2 on b", 32'h1, any_v[2] && !all_v[2]);
    apb(1'b1, cpw_pkg::OFF_UNIT1_CTRL, 32'h0);
    repeat (4) @(posedge ref_clk_i);
    port1_data_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("released", 32'h1, pwm1_pin_o);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    {resetn_i, psel_i, penable_i, pwrite_i, sleep_i, port1_data_i} = 6'h0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset();
    t_rates();
    t_edges();
    t_sleep_route();
    report_and_stop();
  end
endmodule
